// ==== dma_control_status.sv ====
// dma engine control and status registers, coalescing, delay timer and halt logic
//
// Notes on behaviour
// - control bit 0 reads 0, bit 1 reads 1
// - soft reset drains committed work, then resets all but the host port guard flags
// - control bit 3 picks simple or chain mode
// - mode changes only when idle
// - chain mode set before delay interrupt enable
// - bits 4/5 make reads/writes fixed address
// - fixed-address bits stay steady during transfers
// - bit 6 cyclic mode ignores descriptor completed flag
// - cyclic bit set before tail write, held
// - threshold counts completions down, interrupt at zero
// - threshold zero write ignored; reads zero unbuilt
// - status bit 1 shows engine idle
// - byte count or tail write leaves idle
// - status bit 3 shows chain support built
// - status bit 4 data path internal error
// - status bits 5/6 data slave, decode errors
// - status bits 8-10 descriptor engine errors
// - errors halt gracefully; flags held until reset
// - status bits 12-14 events, write one clears
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module dma_control_status
    import dma_cs_pkg::*;
#(
    parameter bit SG_BUILD    = 1'b1,
    parameter int TICK_CYCLES = DELAY_TICK_CYCLES
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    dma_reg_if.device                    link,
    input  wire logic                    xfer_done,
    input  wire logic                    desc_done,
    input  wire logic                    tail_reached,
    input  wire logic                    commit_busy,
    input  wire logic                    data_err_int,
    input  wire logic                    data_err_slv,
    input  wire logic                    data_err_dec,
    input  wire logic                    desc_err_int,
    input  wire logic                    desc_err_slv,
    input  wire logic                    desc_err_dec,
    output logic                         start_simple,
    output logic                         start_chain,
    output logic                         flush,
    output logic                         chain_mode,
    output logic                         fixed_rd,
    output logic                         fixed_wr,
    output logic                         cyclic_mode,
    output logic [31:0]                  src_addr,
    output logic [31:0]                  dst_addr,
    output logic [BYTE_COUNT_W-1:0]      byte_count,
    output logic [31-DESC_ALIGN:0]       cur_desc,
    output logic [31-DESC_ALIGN:0]       tail_desc,
    output logic                         irq
);

    typedef struct packed {
        dev_state_t                 st;
        logic                       idle;
        logic                       mode;
        logic                       fixed_rd;
        logic                       fixed_wr;
        logic                       cyclic;
        logic                       en_done;
        logic                       en_delay;
        logic                       en_err;
        logic [7:0]                 thresh;
        logic [7:0]                 delay_set;
        logic [7:0]                 coal;
        logic [7:0]                 dly;
        logic [15:0]                tick;
        logic [5:0]                 err;
        logic                       ev_done;
        logic                       ev_delay;
        logic                       ev_err;
        logic [31:0]                src;
        logic [31:0]                dst;
        logic [31-DESC_ALIGN:0]     cur;
        logic [31-DESC_ALIGN:0]     tail;
        logic [BYTE_COUNT_W-1:0]    btt;
        logic [31:0]                rdata;
        logic                       ack;
        logic                       start_simple;
        logic                       start_chain;
        logic                       flush;
        logic                       irq;
    } dev_regs_t;

    localparam dev_regs_t REG_RESET = '{st: ST_IDLE, idle: 1'b1, thresh: THRESH_RESET, coal: THRESH_RESET,
                                        delay_set: DELAY_RESET, default: '0};
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

    dev_regs_t r;
    dev_regs_t next_r;

    function automatic logic [31:0] read_word(dev_regs_t s, logic [5:0] a);
        logic [31:0] w;
        w = '0;
        if (a == OFF_CONTROL) begin
            w[CTL_ONE]          = 1'b1;
            w[CTL_SOFT_RESET]   = (s.st == ST_SRESET);
            w[CTL_MODE]         = s.mode;
            w[CTL_FIXED_RD]     = s.fixed_rd;
            w[CTL_FIXED_WR]     = s.fixed_wr;
            w[CTL_CYCLIC]       = s.cyclic;
            w[CTL_EN_DONE]      = s.en_done;
            w[CTL_EN_DELAY]     = s.en_delay;
            w[CTL_EN_ERR]       = s.en_err;
            w[FLD_THRESH +: 8]  = SG_BUILD ? s.thresh : 8'h00;
            w[FLD_DELAY +: 8]   = s.delay_set;
        end else if (a == OFF_STATUS) begin
            w[STA_IDLE]         = s.idle;
            w[STA_BUILD]        = SG_BUILD;
            w[STA_DATA_ERR +: 3] = s.err[2:0];
            w[STA_DESC_ERR +: 3] = s.err[5:3];
            w[STA_EV_DONE]      = s.ev_done;
            w[STA_EV_DELAY]     = s.ev_delay;
            w[STA_EV_ERR]       = s.ev_err;
            w[FLD_THRESH +: 8]  = s.coal;
            w[FLD_DELAY +: 8]   = s.dly;
        end else if (a == OFF_CUR_DESC) begin
            w = {s.cur, 6'h00};
        end else if (a == OFF_TAIL_DESC) begin
            w = {s.tail, 6'h00};
        end else if (a == OFF_SRC_ADDR) begin
            w = s.src;
        end else if (a == OFF_DST_ADDR) begin
            w = s.dst;
        end else if (a == OFF_BYTE_COUNT) begin
            w = {9'h000, s.btt};
        end
        return w;
    endfunction

    always_comb begin
        logic [5:0]  err_set;
        logic [31:0] wd;
        logic        done_ev;
        logic        halted;
        logic        dly_run;
        err_set = {desc_err_dec, desc_err_slv, desc_err_int, data_err_dec, data_err_slv, data_err_int};
        wd      = link.wdata;
        done_ev = (r.st == ST_RUN) && (r.mode ? desc_done : xfer_done);
        halted  = (r.err != 6'h00);
        dly_run = 1'b0;
        next_r  = r;
        next_r.ack          = 1'b0;
        next_r.start_simple = 1'b0;
        next_r.start_chain  = 1'b0;

        if (link.req) begin
            next_r.ack   = 1'b1;
            next_r.rdata = read_word(r, link.addr);
        end
        if (link.req && link.we && r.st != ST_SRESET) begin
            if (link.addr == OFF_CONTROL) begin
                if (wd[CTL_SOFT_RESET]) begin
                    next_r.st    = ST_SRESET;
                    next_r.flush = 1'b1;
                end else begin
                    next_r.mode     = SG_BUILD & wd[CTL_MODE];
                    next_r.fixed_rd = wd[CTL_FIXED_RD];
                    next_r.fixed_wr = wd[CTL_FIXED_WR];
                    next_r.cyclic   = wd[CTL_CYCLIC];
                    next_r.en_done  = wd[CTL_EN_DONE];
                    next_r.en_delay = wd[CTL_EN_DELAY];
                    next_r.en_err   = wd[CTL_EN_ERR];
                    next_r.delay_set = wd[FLD_DELAY +: 8];
                    if (wd[FLD_THRESH +: 8] != 8'h00) begin
                        next_r.thresh = wd[FLD_THRESH +: 8];
                        next_r.coal   = wd[FLD_THRESH +: 8];
                    end
                end
            end else if (link.addr == OFF_STATUS) begin
                next_r.ev_done  = r.ev_done & ~wd[STA_EV_DONE];
                next_r.ev_delay = r.ev_delay & ~wd[STA_EV_DELAY];
                next_r.ev_err   = r.ev_err & ~wd[STA_EV_ERR];
            end else if (link.addr == OFF_CUR_DESC) begin
                next_r.cur = wd[31:DESC_ALIGN];
            end else if (link.addr == OFF_TAIL_DESC) begin
                next_r.tail = wd[31:DESC_ALIGN];
                if (r.mode && r.st == ST_IDLE && !halted) begin
                    next_r.st          = ST_RUN;
                    next_r.idle        = 1'b0;
                    next_r.start_chain = 1'b1;
                end
            end else if (link.addr == OFF_SRC_ADDR) begin
                next_r.src = wd;
            end else if (link.addr == OFF_DST_ADDR) begin
                next_r.dst = wd;
            end else if (link.addr == OFF_BYTE_COUNT) begin
                next_r.btt = wd[BYTE_COUNT_W-1:0];
                if (!r.mode && r.st == ST_IDLE && !halted) begin
                    if (wd[BYTE_COUNT_W-1:0] == '0) begin
                        err_set[0] = 1'b1;
                    end else begin
                        next_r.st           = ST_RUN;
                        next_r.idle         = 1'b0;
                        next_r.start_simple = 1'b1;
                    end
                end
            end
        end

        // sticky error flags; set wins over a status write clear, but soft reset completion clears them
        next_r.err = next_r.err | err_set;
        if (err_set != 6'h00) begin
            next_r.ev_err = 1'b1;
        end

        if (next_r.st != ST_SRESET) begin
            case (r.st)
                ST_RUN: begin
                    if (err_set != 6'h00) begin
                        next_r.st    = ST_DRAIN;
                        next_r.flush = 1'b1;
                    end else if (done_ev && (!r.mode || tail_reached)) begin
                        next_r.st   = ST_IDLE;
                        next_r.idle = 1'b1;
                    end
                end
                ST_DRAIN: begin
                    if (!commit_busy) begin
                        next_r.st    = ST_IDLE;
                        next_r.idle  = 1'b1;
                        next_r.flush = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // completion coalescing
        if (done_ev) begin
            next_r.dly  = 8'h00;
            next_r.tick = 16'h0000;
            if (!r.mode || r.coal <= 8'h01) begin
                next_r.ev_done = 1'b1;
                next_r.coal    = r.thresh;
            end else begin
                next_r.coal = r.coal - 8'h01;
            end
        end

        // delay timer while idle with completions still below threshold
        dly_run = r.mode && r.st == ST_IDLE && r.delay_set != 8'h00 && r.coal != r.thresh;
        if (!dly_run) begin
            if (!done_ev) begin
                next_r.dly  = 8'h00;
                next_r.tick = 16'h0000;
            end
        end else if (r.tick == TICK_LAST) begin
            next_r.tick = 16'h0000;
            if (r.dly + 8'h01 == r.delay_set) begin
                next_r.ev_delay = 1'b1;
                next_r.dly      = 8'h00;
                next_r.coal     = r.thresh;
            end else begin
                next_r.dly = r.dly + 8'h01;
            end
        end else begin
            next_r.tick = r.tick + 16'h0001;
        end

        // soft reset finishes once committed work is gone
        if (r.st == ST_SRESET && !commit_busy) begin
            next_r       = REG_RESET;
            next_r.ack   = link.req;
            next_r.rdata = link.req ? read_word(r, link.addr) : 32'h0000_0000;
        end

        next_r.irq = (next_r.ev_done & next_r.en_done) | (next_r.ev_err & next_r.en_err)
                   | (next_r.ev_delay & next_r.en_delay & next_r.mode);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r <= REG_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign link.rdata   = r.rdata;
    assign link.ack     = r.ack;
    assign link.idle    = r.idle;
    assign start_simple = r.start_simple;
    assign start_chain  = r.start_chain;
    assign flush        = r.flush;
    assign chain_mode   = r.mode;
    assign fixed_rd     = r.fixed_rd;
    assign fixed_wr     = r.fixed_wr;
    assign cyclic_mode  = r.cyclic;
    assign src_addr     = r.src;
    assign dst_addr     = r.dst;
    assign byte_count   = r.btt;
    assign cur_desc     = r.cur;
    assign tail_desc    = r.tail;
    assign irq          = r.irq;

endmodule // dma_control_status

// ==== dma_cs_pkg.sv ====
// shared constants and state types for the dma control/status ends
package dma_cs_pkg;

    // register offsets on the device register port
    localparam logic [5:0]  OFF_CONTROL      = 6'h00;
    localparam logic [5:0]  OFF_STATUS       = 6'h04;
    localparam logic [5:0]  OFF_CUR_DESC     = 6'h08;
    localparam logic [5:0]  OFF_TAIL_DESC    = 6'h10;
    localparam logic [5:0]  OFF_SRC_ADDR     = 6'h18;
    localparam logic [5:0]  OFF_DST_ADDR     = 6'h20;
    localparam logic [5:0]  OFF_BYTE_COUNT   = 6'h28;

    // avalon side of the host port
    localparam logic [7:0]  DEV_SPAN         = 8'h40;
    localparam logic [7:0]  OFF_GUARD_STATUS = 8'h40;

    // control bit positions
    localparam int CTL_ONE        = 1;
    localparam int CTL_SOFT_RESET = 2;
    localparam int CTL_MODE       = 3;
    localparam int CTL_FIXED_RD   = 4;
    localparam int CTL_FIXED_WR   = 5;
    localparam int CTL_CYCLIC     = 6;
    localparam int CTL_EN_DONE    = 12;
    localparam int CTL_EN_DELAY   = 13;
    localparam int CTL_EN_ERR     = 14;
    localparam int FLD_THRESH     = 16;
    localparam int FLD_DELAY      = 24;

    // status bit positions
    localparam int STA_IDLE       = 1;
    localparam int STA_BUILD      = 3;
    localparam int STA_DATA_ERR   = 4;
    localparam int STA_DESC_ERR   = 8;
    localparam int STA_EV_DONE    = 12;
    localparam int STA_EV_DELAY   = 13;
    localparam int STA_EV_ERR     = 14;

    localparam int DESC_ALIGN     = 6;
    localparam int BYTE_COUNT_W   = 23;

    // reset values
    localparam logic [7:0]  THRESH_RESET  = 8'h01;
    localparam logic [7:0]  DELAY_RESET   = 8'h00;
    localparam logic [31:0] CONTROL_RESET = 32'h0001_0002;

    // delay timer granularity
    localparam int CLK_PERIOD_NS     = 10;
    localparam int DELAY_TICK_NS     = 1000;
    localparam int DELAY_TICK_CYCLES = (DELAY_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DRAIN, ST_SRESET} dev_state_t;
    typedef enum logic [1:0] {H_IDLE, H_WAIT, H_DONE} host_state_t;

endpackage

// ==== dma_reg_if.sv ====
// register port between the dma control/status device and its host port
`timescale 1ns/1ps
interface dma_reg_if;
    logic        req;
    logic        we;
    logic [5:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        ack;
    logic        idle;

    modport device (input req, input we, input addr, input wdata, output rdata, output ack, output idle);
    modport ctrl   (output req, output we, output addr, output wdata, input rdata, input ack, input idle);
endinterface

// ==== dma_host_port.sv ====
// avalon-mm host port that forwards software accesses to the dma register port
`timescale 1ns/1ps
module dma_host_port
    import dma_cs_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    dma_reg_if.ctrl          link,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);

    typedef struct packed {
        host_state_t st;
        logic        waitreq;
        logic [31:0] readdata;
        logic        req;
        logic        we;
        logic [5:0]  addr;
        logic [31:0] wdata;
        logic [31:0] shadow;
        logic [3:0]  guard;
    } host_regs_t;

    localparam host_regs_t HOST_RESET = '{st: H_IDLE, waitreq: 1'b1, shadow: CONTROL_RESET, default: '0};

    host_regs_t r;
    host_regs_t next_r;

    always_comb begin
        logic [31:0] w;
        logic [3:0]  g;
        w      = avs_writedata;
        g      = 4'h0;
        next_r = r;
        next_r.req = 1'b0;
        case (r.st)
            H_IDLE: begin
                if (avs_read || avs_write) begin
                    if (avs_address < DEV_SPAN) begin
                        if (avs_write && avs_address[5:0] == OFF_CONTROL && !w[CTL_SOFT_RESET]) begin
                            if (!link.idle && w[CTL_MODE] != r.shadow[CTL_MODE]) begin
                                w[CTL_MODE] = r.shadow[CTL_MODE];
                                g[0]        = 1'b1;
                            end
                            if (!link.idle && w[CTL_FIXED_WR:CTL_FIXED_RD] != r.shadow[CTL_FIXED_WR:CTL_FIXED_RD]) begin
                                w[CTL_FIXED_WR:CTL_FIXED_RD] = r.shadow[CTL_FIXED_WR:CTL_FIXED_RD];
                                g[1] = 1'b1;
                            end
                            if (!link.idle && w[CTL_CYCLIC] != r.shadow[CTL_CYCLIC]) begin
                                w[CTL_CYCLIC] = r.shadow[CTL_CYCLIC];
                                g[2]          = 1'b1;
                            end
                            if (w[CTL_EN_DELAY] && !r.shadow[CTL_EN_DELAY] && !r.shadow[CTL_MODE]) begin
                                w[CTL_EN_DELAY] = 1'b0;
                                g[3]            = 1'b1;
                            end
                            next_r.shadow = w;
                            next_r.guard  = r.guard | g;
                        end else if (avs_write && avs_address[5:0] == OFF_CONTROL) begin
                            next_r.shadow = CONTROL_RESET;
                        end
                        next_r.req   = 1'b1;
                        next_r.we    = avs_write;
                        next_r.addr  = avs_address[5:0];
                        next_r.wdata = w;
                        next_r.st    = H_WAIT;
                    end else begin
                        if (avs_address == OFF_GUARD_STATUS) begin
                            next_r.readdata = {28'h000_0000, r.guard};
                            if (avs_write) begin
                                next_r.guard = r.guard & ~avs_writedata[3:0];
                            end
                        end else begin
                            next_r.readdata = 32'h0000_0000;
                        end
                        next_r.waitreq = 1'b0;
                        next_r.st      = H_DONE;
                    end
                end
            end
            H_WAIT: begin
                if (link.ack) begin
                    next_r.readdata = link.rdata;
                    next_r.waitreq  = 1'b0;
                    next_r.st       = H_DONE;
                end
            end
            default: begin
                next_r.waitreq = 1'b1;
                next_r.st      = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r <= HOST_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign link.req        = r.req;
    assign link.we         = r.we;
    assign link.addr       = r.addr;
    assign link.wdata      = r.wdata;
    assign avs_readdata    = r.readdata;
    assign avs_waitrequest = r.waitreq;

endmodule // dma_host_port

// ==== dma_control_status_checker.sv ====
// assertions on the register port between the two dma ends
`timescale 1ns/1ps
module dma_control_status_checker
    import dma_cs_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        req,
    input wire logic        we,
    input wire logic [5:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic        ack,
    input wire logic        idle
);
    logic       last_rd;
    logic [5:0] last_addr;
    wire        ctl_rd = ack && last_rd && (last_addr == OFF_CONTROL);
    wire        sts_rd = ack && last_rd && (last_addr == OFF_STATUS);

    // remembers what the answered request asked for
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            last_rd   <= 1'b0;
            last_addr <= 6'h00;
        end else begin
            last_rd   <= req && !we;
            last_addr <= addr;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_ack_after_req: assert property (req |=> ack)
        else $error("request not answered one cycle later");
    a_ack_single: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_ack_has_req: assert property (ack |-> $past(req))
        else $error("ack without a request");
    a_ctl_fixed_bits: assert property (ctl_rd |-> rdata[1:0] == 2'b10)
        else $error("control bits 1:0 not 10");
    a_ctl_reserved: assert property (ctl_rd |-> rdata[15] == 1'b0 && rdata[11:7] == 5'h00)
        else $error("control reserved bits not zero");
    a_thresh_nonzero: assert property (ctl_rd |-> rdata[23:16] != 8'h00)
        else $error("threshold reads zero");
    a_sts_build_bit: assert property (sts_rd |-> rdata[3] == 1'b1 && rdata[0] == 1'b0)
        else $error("status build or bit 0 wrong");
    a_sts_idle_bit: assert property (sts_rd |-> rdata[1] == $past(idle))
        else $error("status idle bit differs from idle");
endmodule // dma_control_status_checker

// ==== test_dma_control_status.sv ====
// self-checking bench for the dma control/status ends
`timescale 1ns/1ps
module test_dma_control_status import dma_cs_pkg::*; ;
    logic        ref_clk       = 1'b0;
    logic        rst           = 1'b1;
    logic [7:0]  avs_address   = 8'h00;
    logic        avs_read      = 1'b0;
    logic        avs_write     = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        commit_busy   = 1'b0;
    logic [8:0]  ev            = 9'h000;
    logic        irq;
    logic        flush;
    logic [31:0] rd;
    logic [31:0] ctl;
    logic [31:0] e;
    int          errors  = 0;
    int          n_tests = 0;
    int          seed    = 99992;

    dma_reg_if link ();
    always #5 ref_clk = ~ref_clk;

    dma_host_port i_dma_host_port (.ref_clk(ref_clk), .rst(rst), .link(link), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    dma_control_status #(.TICK_CYCLES(2)) i_dma_control_status (.ref_clk(ref_clk), .rst(rst), .link(link),
        .xfer_done(ev[6]), .desc_done(ev[7]), .tail_reached(ev[8]), .commit_busy(commit_busy),
        .data_err_int(ev[0]), .data_err_slv(ev[1]), .data_err_dec(ev[2]), .desc_err_int(ev[3]),
        .desc_err_slv(ev[4]), .desc_err_dec(ev[5]), .start_simple(), .start_chain(), .flush(flush),
        .chain_mode(), .fixed_rd(), .fixed_wr(), .cyclic_mode(), .src_addr(), .dst_addr(),
        .byte_count(), .cur_desc(), .tail_desc(), .irq(irq));
    dma_control_status_checker i_dma_control_status_checker (.ref_clk(ref_clk), .rst(rst),
        .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
        .ack(link.ack), .idle(link.idle));

    task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !w;
        avs_write     <= w;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        av(1'b0, a, 32'h0000_0000, rd);
        chk(rd, exp);
    endtask

    task automatic pulse(input logic [8:0] v);
        @(posedge ref_clk);
        ev <= v;
        @(posedge ref_clk);
        ev <= 9'h000;
        repeat (3) @(posedge ref_clk);
    endtask

    // writable control bits, zero threshold keeps the old one
    function automatic logic [31:0] exp_ctl(input logic [31:0] old, input logic [31:0] w);
        exp_ctl = (w & 32'hFFFF_5078) | 32'h0000_0002;
        if (w[23:16] == 8'h00) exp_ctl[23:16] = old[23:16];
    endfunction

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        finish_test();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rdchk(8'h00, CONTROL_RESET);
        rdchk(8'h04, 32'h0001_000A);
        rdchk(8'h0C, 32'h0000_0000);
        ctl = CONTROL_RESET;
        for (int i = 0; i < 8; i++) begin
            e = $random(seed) & 32'hFFFF_DFFB;
            if (i == 0) e[23:16] = 8'h00;
            av(1'b1, 8'h00, e, rd);
            ctl = exp_ctl(ctl, e);
            rdchk(8'h00, ctl);
        end
        $display("register readback done");
        av(1'b1, 8'h00, 32'h0001_5000, rd);
        av(1'b1, 8'h28, 32'h0000_0010, rd);
        rdchk(8'h04, 32'h0001_0008);
        pulse(9'h040);
        rdchk(8'h04, 32'h0001_100A);
        chk({31'h0, irq}, 32'h1);
        av(1'b1, 8'h04, 32'h0000_1000, rd);
        rdchk(8'h04, 32'h0001_000A);
        chk({31'h0, irq}, 32'h0);
        $display("simple transfer done");
        av(1'b1, 8'h00, 32'h0003_1008, rd);
        av(1'b1, 8'h10, 32'h0000_0040, rd);
        rdchk(8'h04, 32'h0003_0008);
        pulse(9'h080);
        pulse(9'h080);
        rdchk(8'h04, 32'h0001_0008);
        pulse(9'h180);
        rdchk(8'h04, 32'h0003_100A);
        av(1'b1, 8'h04, 32'h0000_1000, rd);
        av(1'b1, 8'h00, 32'h0203_3008, rd);
        av(1'b1, 8'h10, 32'h0000_0080, rd);
        pulse(9'h180);
        rdchk(8'h04, 32'h0003_200A);
        chk({31'h0, irq}, 32'h1);
        av(1'b1, 8'h04, 32'h0000_2000, rd);
        $display("chain coalescing done");
        for (int i = 0; i < 6; i++) begin
            av(1'b1, 8'h00, 32'h0001_4000, rd);
            av(1'b1, 8'h28, 32'h0000_0004, rd);
            commit_busy <= 1'b1;
            pulse(9'h001 << i);
            e = 32'h0001_4008 | (32'h1 << (i < 3 ? 4 + i : 5 + i));
            rdchk(8'h04, e);
            chk({31'h0, flush}, 32'h1);
            commit_busy <= 1'b0;
            repeat (3) @(posedge ref_clk);
            rdchk(8'h04, e | 32'h2);
            chk({31'h0, flush}, 32'h0);
            chk({31'h0, irq}, 32'h1);
            commit_busy <= 1'b1;
            av(1'b1, 8'h00, 32'h0000_0004, rd);
            rdchk(8'h00, 32'h0001_4006);
            commit_busy <= 1'b0;
            repeat (3) @(posedge ref_clk);
            rdchk(8'h00, CONTROL_RESET);
            rdchk(8'h04, 32'h0001_000A);
        end
        av(1'b1, 8'h28, 32'h0000_0000, rd);
        rdchk(8'h04, 32'h0001_401A);
        av(1'b1, 8'h00, 32'h0000_2000, rd);
        rdchk(8'h00, CONTROL_RESET);
        rdchk(8'h40, 32'h0000_0008);
        $display("error halt and soft reset done");
        finish_test();
    end
endmodule // test_dma_control_status
